//--- core/lsc_defines.vh
// Constants for the light sensor command and readout block
//----------------------------------------------------------------
// Operation
//----------------------------------------------------------------
`ifndef LSC_DEFINES_VH
`define LSC_DEFINES_VH

//----------------------------------------------------------------
// Bus
//----------------------------------------------------------------
`define LSC_ADDR_HI       4'h8
`define LSC_BITS_PER_BYTE 4'h8
`define LSC_BYTES_INT     2'h1
`define LSC_BYTES_EXT     2'h3

//----------------------------------------------------------------
// Commands and fields
//----------------------------------------------------------------
`define LSC_CMD_PDOWN     8'h8C
`define LSC_CMD_RESET     8'h0C
`define LSC_CMD_INT_D1    8'h00
`define LSC_CMD_INT_D2    8'h04
`define LSC_CMD_INT_DIFF  8'h08
`define LSC_CMD_EXT_D1    8'h30
`define LSC_CMD_EXT_D2    8'h34
`define LSC_CMD_EXT_DIFF  8'h38
`define LSC_CMD_RST_VAL   8'h00
`define LSC_TEST_BIT      7
`define LSC_SEL_HI        3
`define LSC_SEL_LO        2
`define LSC_SEL_D2        2'h1
`define LSC_SEL_DIFF      2'h2

//----------------------------------------------------------------
// Timing
//----------------------------------------------------------------
`define LSC_INT_CYCLES    16'h8000
`define LSC_CNT_MAX       16'hFFFF

`endif

//--- core/lsc_core.v
// Command decode, two-wire slave and conversion sequencer of the light sensor
`timescale 1ns/1ps
`default_nettype none
`include "lsc_defines.vh"

module lsc_core (
   input  wire       clk,
   input  wire       srst,
   input  wire       scl_in,
   input  wire       sda_in,
   output wire       sda_out,
   output reg        sda_oe,
   input  wire       addr_sel_bit0,
   input  wire       addr_sel_bit1,
   input  wire       addr_sel_bit2,
   input  wire       osc_in,
   input  wire       adc_pulse_in,
   output reg        adc_power_down,
   output reg        integrating,
   output reg        covered_diode_sel
);

   //----------------------------------------------------------------
   // States
   //----------------------------------------------------------------
   localparam I_IDLE = 3'h0;
   localparam I_ADDR = 3'h1;
   localparam I_AACK = 3'h2;
   localparam I_WR   = 3'h3;
   localparam I_WACK = 3'h4;
   localparam I_RD   = 3'h5;
   localparam I_RACK = 3'h6;

   localparam C_IDLE = 2'h0;
   localparam C_INT  = 2'h1;
   localparam C_EXT  = 2'h2;
   localparam C_TAIL = 2'h3;

   //----------------------------------------------------------------
   // Input synchronisers
   //----------------------------------------------------------------
   // Bit order: scl, sda, a0, a1, a2, osc, pulse
   wire [6:0] raw_in = {adc_pulse_in, osc_in, addr_sel_bit2, addr_sel_bit1,
                        addr_sel_bit0, sda_in, scl_in};
   reg  [6:0] sync1;
   reg  [6:0] sync2;
   reg  [6:0] sync3;

   always @(posedge clk) begin
      if (srst) begin
         sync1 <= 7'h7F;
         sync2 <= 7'h7F;
         sync3 <= 7'h7F;
      end else begin
         sync1 <= raw_in;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   wire scl      = sync2[0];
   wire sda      = sync2[1];
   wire scl_rise = sync2[0] & ~sync3[0];
   wire scl_fall = ~sync2[0] & sync3[0];
   wire start_c  = sync2[0] & sync3[0] & sync3[1] & ~sync2[1];
   wire stop_c   = sync2[0] & sync3[0] & ~sync3[1] & sync2[1];
   wire osc_tick = sync2[5] & ~sync3[5];
   wire adc_tick = sync2[6] & ~sync3[6];
   wire [6:0] my_addr = {`LSC_ADDR_HI, sync2[4:2]};

   // Open drain: only ever pulls low
   assign sda_out = 1'h0;

   //----------------------------------------------------------------
   // Registers seen by the bus
   //----------------------------------------------------------------
   reg  [7:0]  cmd;
   reg  [15:0] result;
   reg  [15:0] cycles;

   wire [1:0] sel    = cmd[`LSC_SEL_HI:`LSC_SEL_LO];
   wire is_int = (cmd == `LSC_CMD_INT_D1) | (cmd == `LSC_CMD_INT_D2) |
                 (cmd == `LSC_CMD_INT_DIFF);
   wire is_ext = (cmd == `LSC_CMD_EXT_D1) | (cmd == `LSC_CMD_EXT_D2) |
                 (cmd == `LSC_CMD_EXT_DIFF);
   wire is_test = cmd[`LSC_TEST_BIT] & (cmd != `LSC_CMD_PDOWN);
   // Cycle count only offered in external modes
   wire [1:0] last_idx = is_ext ? `LSC_BYTES_EXT : `LSC_BYTES_INT;

   reg  [1:0] byte_idx;
   reg  [7:0] rd_byte;

   always @* begin
      case (byte_idx)
         2'h0:    rd_byte = is_test ? cmd : result[7:0];
         2'h1:    rd_byte = result[15:8];
         2'h2:    rd_byte = cycles[7:0];
         default: rd_byte = cycles[15:8];
      endcase
   end

   //----------------------------------------------------------------
   // Two-wire slave
   //----------------------------------------------------------------
   reg [2:0] i_state;
   reg [3:0] bit_cnt;
   reg [7:0] shreg;
   reg [7:0] pending;
   reg       rw;
   reg       got_byte;
   reg       wr_active;
   reg       ack_ok;
   reg       exec;

   always @(posedge clk) begin
      if (srst) begin
         i_state   <= I_IDLE;
         bit_cnt   <= 4'h0;
         shreg     <= 8'h00;
         pending   <= 8'h00;
         rw        <= 1'h0;
         got_byte  <= 1'h0;
         wr_active <= 1'h0;
         ack_ok    <= 1'h0;
         exec      <= 1'h0;
         sda_oe    <= 1'h0;
         byte_idx  <= 2'h0;
         cmd       <= `LSC_CMD_RST_VAL;
      end else begin
         exec <= 1'h0;
         if (start_c | stop_c) begin
            // A finished write takes effect at its stop or repeated start
            if (wr_active) begin
               exec <= 1'h1;
               if (got_byte)
                  cmd <= pending;
            end                               // else rerun
            wr_active <= 1'h0;
            got_byte  <= 1'h0;
            sda_oe    <= 1'h0;
            bit_cnt   <= 4'h0;
            byte_idx  <= 2'h0;
            i_state   <= start_c ? I_ADDR : I_IDLE;
         end else begin
            case (i_state)
               I_ADDR: begin
                  if (scl_rise) begin
                     shreg   <= {shreg[6:0], sda};
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (scl_fall && bit_cnt == `LSC_BITS_PER_BYTE) begin
                     if (shreg[7:1] == my_addr) begin
                        rw      <= shreg[0];
                        sda_oe  <= 1'h1;
                        i_state <= I_AACK;
                     end else begin
                        i_state <= I_IDLE;
                     end
                  end
               end
               I_AACK: begin
                  if (scl_fall) begin
                     bit_cnt <= 4'h0;
                     if (rw) begin
                        byte_idx <= 2'h0;
                        shreg    <= rd_byte;
                        sda_oe   <= ~rd_byte[7];
                        i_state  <= I_RD;
                     end else begin
                        sda_oe    <= 1'h0;
                        wr_active <= 1'h1;
                        i_state   <= I_WR;
                     end
                  end
               end
               I_WR: begin
                  if (scl_rise) begin
                     shreg   <= {shreg[6:0], sda};
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (scl_fall && bit_cnt == `LSC_BITS_PER_BYTE) begin
                     pending  <= shreg;
                     got_byte <= 1'h1;
                     sda_oe   <= 1'h1;
                     i_state  <= I_WACK;
                  end
               end
               I_WACK: begin
                  if (scl_fall) begin
                     sda_oe  <= 1'h0;
                     bit_cnt <= 4'h0;
                     i_state <= I_WR;
                  end
               end
               I_RD: begin
                  if (scl_rise) begin
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (scl_fall) begin
                     if (bit_cnt == `LSC_BITS_PER_BYTE) begin
                        sda_oe  <= 1'h0;
                        i_state <= I_RACK;
                     end else begin
                        shreg  <= {shreg[6:0], 1'h0};
                        sda_oe <= ~shreg[6];
                     end
                  end
               end
               I_RACK: begin
                  if (scl_rise) begin
                     // Master NAK or byte limit ends sending
                     ack_ok <= ~sda & (byte_idx != last_idx);
                     if (!(~sda & (byte_idx != last_idx)))
                        i_state <= I_IDLE;
                     else
                        byte_idx <= byte_idx + 2'h1;
                  end else if (scl_fall && ack_ok) begin
                     ack_ok  <= 1'h0;
                     bit_cnt <= 4'h0;
                     shreg   <= rd_byte;
                     sda_oe  <= ~rd_byte[7];
                     i_state <= I_RD;
                  end
               end
               default: i_state <= I_IDLE;
            endcase
         end
      end
   end

   //----------------------------------------------------------------
   // Conversion sequencer
   //----------------------------------------------------------------
   reg  [1:0]  c_state;
   reg  [15:0] conv_cnt;
   reg  [15:0] cyc_cnt;
   reg  [15:0] half_len;
   reg         diff_run;
   reg  [15:0] next_conv;
   reg  [15:0] next_cyc;

   // Unsigned counts saturate; difference wraps as two's complement
   always @* begin
      next_conv = conv_cnt;
      if (adc_tick && (c_state != C_IDLE)) begin
         if (covered_diode_sel && diff_run)
            next_conv = conv_cnt - 16'h0001;
         else if (diff_run || conv_cnt != `LSC_CNT_MAX)
            next_conv = conv_cnt + 16'h0001;
      end
      next_cyc = cyc_cnt;
      if (osc_tick && cyc_cnt != `LSC_CNT_MAX)
         next_cyc = cyc_cnt + 16'h0001;
   end

   always @(posedge clk) begin
      if (srst) begin
         c_state           <= C_IDLE;
         conv_cnt          <= 16'h0000;
         cyc_cnt           <= 16'h0000;
         half_len          <= 16'h0000;
         diff_run          <= 1'h0;
         result            <= 16'h0000;
         cycles            <= 16'h0000;
         adc_power_down    <= 1'h0;
         integrating       <= 1'h0;
         covered_diode_sel <= 1'h0;
      end else if (exec) begin
         adc_power_down <= (cmd == `LSC_CMD_PDOWN);
         if (cmd == `LSC_CMD_PDOWN) begin
            c_state     <= C_IDLE;
            integrating <= 1'h0;
         end else if (cmd == `LSC_CMD_RESET) begin
            conv_cnt    <= 16'h0000;
            cyc_cnt     <= 16'h0000;
            cycles      <= 16'h0000;
            c_state     <= C_IDLE;
            integrating <= 1'h0;
         end else if (is_int || is_ext) begin
            if (is_ext && c_state == C_EXT && diff_run && covered_diode_sel) begin
               // Open diode now runs as long as the covered one did
               half_len          <= cyc_cnt;
               cyc_cnt           <= 16'h0000;
               covered_diode_sel <= 1'h0;
               c_state           <= C_TAIL;
            end else begin
               if (is_ext && c_state == C_EXT) begin
                  result <= conv_cnt;
                  cycles <= cyc_cnt;
               end
               conv_cnt          <= 16'h0000;
               cyc_cnt           <= 16'h0000;
               diff_run          <= (sel == `LSC_SEL_DIFF);
               covered_diode_sel <= (sel == `LSC_SEL_DIFF) | (sel == `LSC_SEL_D2);
               integrating       <= 1'h1;
               c_state           <= is_int ? C_INT : C_EXT;
            end
         end
         // Test and unknown codes leave the conversion alone
      end else begin
         conv_cnt <= next_conv;
         cyc_cnt  <= next_cyc;
         case (c_state)
            C_INT: begin
               if (next_cyc == `LSC_INT_CYCLES) begin
                  if (diff_run && covered_diode_sel) begin
                     covered_diode_sel <= 1'h0;
                     cyc_cnt           <= 16'h0000;
                  end else begin
                     result      <= next_conv;
                     cycles      <= next_cyc;
                     integrating <= 1'h0;
                     c_state     <= C_IDLE;
                  end
               end
            end
            C_TAIL: begin
               if (next_cyc >= half_len) begin
                  result            <= next_conv;
                  cycles            <= half_len;
                  conv_cnt          <= 16'h0000;
                  cyc_cnt           <= 16'h0000;
                  covered_diode_sel <= 1'h1;
                  c_state           <= C_EXT;
               end
            end
            C_EXT:   c_state <= C_EXT;
            default: c_state <= C_IDLE;
         endcase
      end
   end

endmodule // lsc_core

`default_nettype wire

//--- tb/lsc_assertions.sv
// Port-level checks on the light sensor core
`timescale 1ns/1ps
`default_nettype none
module lsc_assertions (
   input wire logic clk,
   input wire logic srst,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic addr_sel_bit0,
   input wire logic addr_sel_bit1,
   input wire logic addr_sel_bit2,
   input wire logic osc_in,
   input wire logic adc_pulse_in,
   input wire logic adc_power_down,
   input wire logic integrating,
   input wire logic covered_diode_sel
);
   //----------------------------------------------------------------
   // Checks
   //----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   a_reset_idle: assert property (disable iff (1'b0) srst |=>
      !sda_oe && !integrating && !adc_power_down && !covered_diode_sel) else $error("not idle after reset");
   a_sda_low_only: assert property (sda_out == 1'b0) else $error("data pin driven high");
   a_oe_moves_low: assert property ($changed(sda_oe) |-> !scl_in) else $error("data moved in clock high");
   // SDA drive must hold for 8 clocks after each clock rise
   a_oe_holds_high: assert property ($rose(scl_in) |-> $stable(sda_oe) [*8])
      else $error("data moved after clock rise");
   a_oe_lag: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in, 2)) else $error("drive too early");
   a_pdown_idle: assert property (adc_power_down |-> !integrating) else $error("running in power down");
   a_pdown_at_stop: assert property ($changed(adc_power_down) |-> scl_in) else $error("power change off stop");
   a_integ_start: assert property ($rose(integrating) |-> scl_in && $past(scl_in, 3))
      else $error("conversion start off stop");
endmodule // lsc_assertions

bind lsc_core lsc_assertions u_chk (.clk(clk), .srst(srst), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel_bit0(addr_sel_bit0), .addr_sel_bit1(addr_sel_bit1),
   .addr_sel_bit2(addr_sel_bit2), .osc_in(osc_in), .adc_pulse_in(adc_pulse_in),
   .adc_power_down(adc_power_down), .integrating(integrating), .covered_diode_sel(covered_diode_sel));
`default_nettype wire

//--- tb/lsc_bus_master.sv
// Two-wire bus master model for the light sensor core
`timescale 1ns/1ps
`default_nettype none
module lsc_bus_master (
   input  wire logic clk,
   input  wire logic sda_line,
   output var  logic scl,
   output var  logic sda_low
);
   //----------------------------------------------------------------
   // Bus phases, SCL rests high and SDA floats to its pull-up
   //----------------------------------------------------------------
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic q;
      repeat (5) @(posedge clk);
      #1;
   endtask
   task automatic start;
      sda_low = 1'b1;
      q();
      scl = 1'b0;
      q();
   endtask
   // Master may end after any byte it has refused
   task automatic stop;
      sda_low = 1'b1;
      q();
      scl = 1'b1;
      q();
      sda_low = 1'b0;
      q();
   endtask
   task automatic bit_io(input logic b, output logic r);
      sda_low = !b;
      q();
      scl = 1'b1;
      q();
      r = sda_line;
      q();
      scl = 1'b0;
      q();
   endtask
   task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] r, output logic ack);
      for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
      bit_io(ack_in, ack);
   endtask
endmodule // lsc_bus_master
`default_nettype wire

//--- tb/lsc_core_tb.sv
// Self-checking bench of the light sensor core
`timescale 1ns/1ps
`default_nettype none
module lsc_core_tb;
   typedef struct packed {logic [7:0] cmd; logic [15:0] no; logic [15:0] na; logic sel; logic chk;} lsc_row_t;
   logic       clk = 1'b0, srst = 1'b1, osc_in = 1'b0, adc_pulse_in = 1'b0;
   logic [2:0] asel = 3'h5;
   logic [6:0] dev = 7'h45;
   logic       scl, sda_low, sda_oe, sda_out, pdn, integ, csel;
   wire logic  sda = !(sda_low || sda_oe);
   int         num_errors = 0, n_checks = 0;
   lsc_row_t   rows [6] = '{'{8'h08, 16'h4, 16'h1, 1'b1, 1'b0}, '{8'h04, 16'h4, 16'h1, 1'b1, 1'b0},
      '{8'h00, 16'h4, 16'h1, 1'b0, 1'b0}, '{8'h38, 16'h4, 16'h1, 1'b1, 1'b0},
      '{8'h34, 16'h28, 16'h9, 1'b1, 1'b1}, '{8'h30, 16'h140, 16'h12C, 1'b0, 1'b1}};
   always #4 clk = ~clk;
   lsc_core dut (.clk(clk), .srst(srst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .addr_sel_bit0(asel[0]), .addr_sel_bit1(asel[1]), .addr_sel_bit2(asel[2]), .osc_in(osc_in),
      .adc_pulse_in(adc_pulse_in), .adc_power_down(pdn), .integrating(integ), .covered_diode_sel(csel));
   lsc_bus_master m (.clk(clk), .sda_line(sda), .scl(scl), .sda_low(sda_low));
   //----------------------------------------------------------------
   // Helpers
   //----------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict;
      $display("errors=%0d checks=%0d", num_errors, n_checks);
      if (num_errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [6:0] a, input logic has_cmd, input logic [7:0] c, input logic nak);
      logic [7:0] r;
      logic       k;
      m.start();
      m.xfer({a, 1'b0}, 1'b1, r, k);
      chk({15'h0, k}, {15'h0, nak});
      if (has_cmd && !nak) m.xfer(c, 1'b1, r, k);
      m.stop();
      repeat (8) @(posedge clk);
      #1;
   endtask
   task automatic rd(input int n, input logic [31:0] e);
      logic [7:0] r;
      logic       k;
      m.start();
      m.xfer({dev, 1'b1}, 1'b1, r, k);
      chk({15'h0, k}, 16'h0);
      for (int i = 0; i < n; i++) begin
         m.xfer(8'hFF, i == n - 1, r, k);
         chk({8'h0, r}, {8'h0, e[8*i+:8]});
      end
      m.stop();
      repeat (8) @(posedge clk);
      #1;
   endtask
   // Only sent with the bus quiet, so period counts stay exact
   task automatic pulses(input int no, input int na);
      for (int i = 0; i < no || i < na; i++) begin
         osc_in = (i < no);
         adc_pulse_in = (i < na);
         repeat (2) @(posedge clk);
         #1;
         osc_in = 1'b0;
         adc_pulse_in = 1'b0;
         repeat (2) @(posedge clk);
         #1;
      end
   endtask
   //----------------------------------------------------------------
   // Sequence
   //----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      #1;
      srst = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      rd(3, 32'h00FF0000);
      foreach (rows[j]) begin
         wr(dev, 1'b1, 8'h0C, 1'b0);
         wr(dev, 1'b1, rows[j].cmd, 1'b0);
         chk({14'h0, csel, integ}, {14'h0, rows[j].sel, 1'b1});
         pulses(rows[j].no, rows[j].na);
         if (rows[j].chk) begin
            wr(dev, 1'b1, rows[j].cmd, 1'b0);
            rd(4, {rows[j].no, rows[j].na});
         end
      end
      wr(dev, 1'b1, 8'hA5, 1'b0);
      rd(2, 32'h01A5);
      wr(dev, 1'b1, 8'h8C, 1'b0);
      chk({14'h0, pdn, integ}, 16'h2);
      wr(dev, 1'b0, 8'h00, 1'b0);
      chk({15'h0, pdn}, 16'h1);
      wr(dev, 1'b1, 8'h0C, 1'b0);
      chk({15'h0, pdn}, 16'h0);
      rd(2, 32'h012C);
      wr(dev, 1'b1, 8'h00, 1'b0);
      pulses(10, 5);
      rd(3, 32'hFF012C);
      wr(dev, 1'b1, 8'h0C, 1'b0);
      wr(dev, 1'b1, 8'h30, 1'b0);
      pulses(7, 3);
      wr(dev, 1'b0, 8'h00, 1'b0);
      rd(4, 32'h00070003);
      asel = 3'h2;
      dev = 7'h42;
      repeat (4) @(posedge clk);
      #1;
      wr(7'h42, 1'b0, 8'h00, 1'b0);
      wr(7'h45, 1'b1, 8'h00, 1'b1);
      //----------------------------------------------------------------
      // Full internal period, one osc edge every second clock
      //----------------------------------------------------------------
      wr(dev, 1'b1, 8'h00, 1'b0);
      for (int i = 0; i < 32768; i++) begin
         osc_in = 1'b1;
         adc_pulse_in = i[1];
         @(posedge clk);
         #1;
         osc_in = 1'b0;
         @(posedge clk);
         #1;
      end
      adc_pulse_in = 1'b0;
      repeat (8) @(posedge clk);
      #1;
      chk({15'h0, integ}, 16'h0);
      // Read only once the period is over
      rd(3, 32'hFF2000);
      //----------------------------------------------------------------
      // Reset in mid-run
      //----------------------------------------------------------------
      wr(dev, 1'b1, 8'h34, 1'b0);
      srst = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      srst = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk({13'h0, pdn, integ, csel}, 16'h0);
      rd(3, 32'hFF0000);
      print_verdict();
   end
   initial begin
      repeat (100000) @(posedge clk);
      num_errors++;
      print_verdict();
   end
endmodule // lsc_core_tb
`default_nettype wire
